// ---- shared/dsx_consts.vh ----
`ifndef DSX_CONSTS_VH
`define DSX_CONSTS_VH

// Address decoration
`define DSX_REGION_HI 31
`define DSX_REGION_LO 29
`define DSX_REGION_PERIPH 3'h2
`define DSX_OP_HI 28
`define DSX_OP_LO 26
`define DSX_OP_XOR 3'h3
`define DSX_BFI_BIT 28
`define DSX_LSB_HI 27
`define DSX_LSB_LO 23
`define DSX_WM1_HI 22
`define DSX_WM1_LO 19

// Decoration strip masks
`define DSX_XOR_ADDR_MASK 32'he00fffff
`define DSX_BFI_ADDR_MASK 32'he007ffff

// Bus transfer codes
`define DSX_TRANS_IDLE 2'h0
`define DSX_TRANS_NONSEQ 2'h2
`define DSX_SIZE_BYTE 3'h0
`define DSX_SIZE_HALF 3'h1
`define DSX_SIZE_WORD 3'h2

// Reset values
`define DSX_RST_ADDR 32'h00000000
`define DSX_RST_DATA 32'h00000000

`endif

// ---- src/dsx_bit_manip_engine.v ----
// Functional notes
// - Decorated XOR store: read target, XOR with write data, write back atomically.
// - Read and write use the master's write size: byte, halfword or word.
// - XOR decoded when addr[31:29]=010 and addr[28:26]=011; unused bits ignored.
// - XOR real address is decorated address ANDed with e00fffff.
// - Cycle x: forward address, decode, turn write into read, capture attributes.
// - Cycle x+1: reissue captured address and attributes as a write.
// - Cycle x+1 data phase: combine read data with write data, register result.
// - Cycle x+2 data phase: drive registered result as the write data.
// - Field insert decoded on addr[28]; LSB in 27:23, width-1 in 22:19.
// - Field insert real address is decorated address ANDed with e007ffff.
// - Mask of w+1 ones shifted by b; clear masked bits, OR masked write data.
// - Width-minus-one of zero inserts a single bit.
// - Field bits beyond the container width are dropped.
// - Slave wait states stall the master cycle for cycle.
// - Address and data phases are pipelined.
`include "dsx_consts.vh"
`default_nettype none

module dsx_bit_manip_engine
(
  input wire core_clk,
  input wire rstn,
  input wire [31:0] up_haddr,
  input wire [1:0] up_htrans,
  input wire up_hwrite,
  input wire [2:0] up_hsize,
  input wire [3:0] up_hprot,
  input wire [31:0] up_hwdata,
  output reg [31:0] up_hrdata,
  output reg up_hready,
  output reg up_hresp,
  output reg [31:0] dn_haddr,
  output reg [1:0] dn_htrans,
  output reg dn_hwrite,
  output reg [2:0] dn_hsize,
  output reg [3:0] dn_hprot,
  output reg dn_hmastlock,
  output reg [31:0] dn_hwdata,
  input wire [31:0] dn_hrdata,
  input wire dn_hready,
  input wire dn_hresp
);

  localparam [1:0] ST_PASS = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] addr_reg;
  reg [2:0] size_reg;
  reg [3:0] prot_reg;
  reg bfi_reg;
  reg [4:0] lsb_reg;
  reg [3:0] wm1_reg;
  reg [31:0] result_reg;
  reg [31:0] result_next;

  wire periph_hit;
  wire xor_hit;
  wire bfi_hit;
  wire size_ok;
  wire addr_accept;
  wire decorated_store;
  wire [31:0] strip_addr;
  wire [31:0] rd_container;
  wire [31:0] wr_container;
  wire [31:0] field_mask;
  wire [31:0] modified;

  // Right-align the active lanes of a bus word
  function [31:0] lane_extract;
    input [31:0] data;
    input [2:0] size;
    input [1:0] addr_lo;
    begin
      if (size == `DSX_SIZE_BYTE)
      begin
        case (addr_lo)
          2'h0: lane_extract = {24'h000000, data[7:0]};
          2'h1: lane_extract = {24'h000000, data[15:8]};
          2'h2: lane_extract = {24'h000000, data[23:16]};
          default: lane_extract = {24'h000000, data[31:24]};
        endcase
      end
      else if (size == `DSX_SIZE_HALF)
      begin
        if (addr_lo[1])
          lane_extract = {16'h0000, data[31:16]};
        else
          lane_extract = {16'h0000, data[15:0]};
      end
      else
      begin
        lane_extract = data;
      end
    end
  endfunction

  // Spread a right-aligned container over every lane
  function [31:0] lane_replicate;
    input [31:0] data;
    input [2:0] size;
    begin
      if (size == `DSX_SIZE_BYTE)
        lane_replicate = {4{data[7:0]}};
      else if (size == `DSX_SIZE_HALF)
        lane_replicate = {2{data[15:0]}};
      else
        lane_replicate = data;
    end
  endfunction

  // Field mask clipped to the container
  function [31:0] build_mask;
    input [2:0] size;
    input [4:0] lsb;
    input [3:0] wm1;
    reg [4:0] width;
    reg [31:0] ones;
    reg [31:0] shifted;
    reg [3:0] wm_eff;
    begin
      // Byte stores carry only three width bits; bit 22 is don't-care there
      if (size == `DSX_SIZE_BYTE)
        wm_eff = {1'b0, wm1[2:0]};
      else
        wm_eff = wm1;
      width = {1'b0, wm_eff} + 5'h01;
      ones = (32'h00000001 << width) - 32'h00000001;
      // Bits shifted past the container fall off, which clips the field
      if (size == `DSX_SIZE_BYTE)
      begin
        shifted = ones << lsb[2:0];
        build_mask = {24'h000000, shifted[7:0]};
      end
      else if (size == `DSX_SIZE_HALF)
      begin
        shifted = ones << lsb[3:0];
        build_mask = {16'h0000, shifted[15:0]};
      end
      else
      begin
        shifted = ones << lsb;
        build_mask = shifted;
      end
    end
  endfunction

  // Decorated loads and other decorations are passed untouched
  assign periph_hit = (up_haddr[`DSX_REGION_HI:`DSX_REGION_LO] == `DSX_REGION_PERIPH);
  assign xor_hit = periph_hit && (up_haddr[`DSX_OP_HI:`DSX_OP_LO] == `DSX_OP_XOR);
  assign bfi_hit = periph_hit && up_haddr[`DSX_BFI_BIT];
  // Sizes above a word are never decorated
  assign size_ok = (up_hsize == `DSX_SIZE_BYTE) || (up_hsize == `DSX_SIZE_HALF)
    || (up_hsize == `DSX_SIZE_WORD);
  assign addr_accept = up_htrans[1] && up_hready;
  assign decorated_store = addr_accept && up_hwrite && size_ok && (xor_hit || bfi_hit);
  assign strip_addr = bfi_hit ? (up_haddr & `DSX_BFI_ADDR_MASK)
    : (up_haddr & `DSX_XOR_ADDR_MASK);

  assign rd_container = lane_extract(dn_hrdata, size_reg, addr_reg[1:0]);
  assign wr_container = lane_extract(up_hwdata, size_reg, addr_reg[1:0]);
  assign field_mask = build_mask(size_reg, lsb_reg, wm1_reg);
  assign modified = bfi_reg ? ((rd_container & ~field_mask) | (wr_container & field_mask))
    : (rd_container ^ wr_container);

  // Address phase toward the slave
  always @*
  begin
    dn_haddr = up_haddr;
    dn_htrans = up_htrans;
    dn_hwrite = up_hwrite;
    dn_hsize = up_hsize;
    dn_hprot = up_hprot;
    dn_hmastlock = 1'b0;
    if (state_reg == ST_READ)
    begin
      dn_haddr = addr_reg;
      dn_hwrite = 1'b1;
      dn_hsize = size_reg;
      dn_hprot = prot_reg;
      // Lock spans read and write-back so no other master slips between
      dn_hmastlock = 1'b1;
      // Cancel the write if the read is being errored
      dn_htrans = dn_hresp ? `DSX_TRANS_IDLE : `DSX_TRANS_NONSEQ;
    end
    else if (decorated_store)
    begin
      dn_haddr = strip_addr;
      dn_hwrite = 1'b0;
      dn_hmastlock = 1'b1;
    end
  end

  // Data phase and handshakes
  always @*
  begin
    dn_hwdata = up_hwdata;
    up_hrdata = dn_hrdata;
    up_hresp = dn_hresp;
    up_hready = dn_hready;
    if (state_reg == ST_READ)
    begin
      // Only an error ends the master transfer here
      up_hready = dn_hready && dn_hresp;
      // Read word only feeds the merge, never the master
      up_hrdata = `DSX_RST_DATA;
    end
    else if (state_reg == ST_WRITE)
    begin
      dn_hwdata = result_reg;
    end
  end

  always @*
  begin
    state_next = state_reg;
    result_next = result_reg;
    case (state_reg)
      ST_PASS:
      begin
        if (decorated_store)
          state_next = ST_READ;
      end
      ST_READ:
      begin
        if (dn_hready)
        begin
          if (dn_hresp)
          begin
            state_next = ST_PASS;
          end
          else
          begin
            result_next = lane_replicate(modified, size_reg);
            state_next = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        if (dn_hready)
        begin
          // Write-back slot doubles as the next store's read stage
          if (decorated_store)
            state_next = ST_READ;
          else
            state_next = ST_PASS;
        end
      end
      default:
      begin
        state_next = ST_PASS;
      end
    endcase
  end

  // Result stands until the write-back data phase is accepted
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= ST_PASS;
      result_reg <= `DSX_RST_DATA;
    end
    else
    begin
      state_reg <= state_next;
      result_reg <= result_next;
    end
  end

  // Decoration capture at cycle x
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_reg <= `DSX_RST_ADDR;
      size_reg <= `DSX_SIZE_BYTE;
      prot_reg <= 4'h0;
      bfi_reg <= 1'b0;
      lsb_reg <= 5'h00;
      wm1_reg <= 4'h0;
    end
    // Never while reading, so a pending write-back keeps its target
    else if (decorated_store && (state_reg != ST_READ))
    begin
      addr_reg <= strip_addr;
      size_reg <= up_hsize;
      prot_reg <= up_hprot;
      bfi_reg <= bfi_hit;
      lsb_reg <= up_haddr[`DSX_LSB_HI:`DSX_LSB_LO];
      wm1_reg <= up_haddr[`DSX_WM1_HI:`DSX_WM1_LO];
    end
  end

endmodule // dsx_bit_manip_engine

`default_nettype wire

// ---- tb/dsx_chk_sva.sv ----
`default_nettype none
module dsx_chk_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [31:0] up_haddr,
  input wire logic [1:0] up_htrans,
  input wire logic up_hwrite,
  input wire logic [2:0] up_hsize,
  input wire logic up_hready,
  input wire logic [3:0] up_hprot,
  input wire logic [31:0] dn_haddr,
  input wire logic [1:0] dn_htrans,
  input wire logic dn_hwrite,
  input wire logic [2:0] dn_hsize,
  input wire logic [3:0] dn_hprot,
  input wire logic dn_hmastlock,
  input wire logic dn_hready,
  input wire logic dn_hresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic dec;
  assign dec = up_htrans[1] && up_hready && up_hwrite && up_hsize <= 3'h2
    && up_haddr[31:29] == 3'h2 && (up_haddr[28] || up_haddr[28:26] == 3'h3);
  a_read_first: assert property (dec |-> !dn_hwrite && dn_htrans[1])
    else $error("decorated store not issued as read");
  a_xor_strip: assert property (
    dec && !up_haddr[28] |-> dn_haddr == (up_haddr & 32'he00fffff))
    else $error("xor address not stripped");
  a_insert_strip: assert property (
    dec && up_haddr[28] |-> dn_haddr == (up_haddr & 32'he007ffff))
    else $error("insert address not stripped");
  a_write_reissue: assert property (
    dec |=> dn_hresp || dn_hwrite && dn_htrans[1]
      && dn_haddr == $past(dn_haddr) && dn_hsize == $past(up_hsize))
    else $error("write phase not reissued");
  a_prot_kept: assert property (dec |=> dn_hresp || dn_hprot == $past(up_hprot))
    else $error("attributes not reissued");
  a_master_held: assert property (dec |=> !up_hready)
    else $error("master not held");
  a_lock_kept: assert property (dec |-> dn_hmastlock ##1 dn_hmastlock)
    else $error("sequence not locked");
  a_wait_pass: assert property (!dn_hready |-> !up_hready)
    else $error("slave wait not passed");
  a_phase_bound: assert property (dec |=> ##[1:10] up_hready)
    else $error("store never completed");
endmodule // dsx_chk_sva
bind dsx_bit_manip_engine dsx_chk_sva u_chk (.core_clk, .rstn, .up_haddr,
  .up_htrans, .up_hwrite, .up_hsize, .up_hready, .up_hprot, .dn_haddr, .dn_htrans,
  .dn_hwrite, .dn_hsize, .dn_hprot, .dn_hmastlock, .dn_hready, .dn_hresp);
`default_nettype wire

// ---- tb/dsx_slave_model.sv ----
`default_nettype none
module dsx_slave_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic [1:0] waits,
  output logic [31:0] hrdata,
  output logic hready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic [31:0] a, m, merged, rd_word;
  logic act, wr, wr_now;
  logic [1:0] cnt;
  // Bypass so a read taken on a write's last edge sees the new word
  always_comb
  begin
    wr_now = act && hready && wr;
    merged = mem[a[5:2]] & ~m | hwdata & m;
    rd_word = wr_now && a[5:2] == haddr[5:2] ? merged : mem[haddr[5:2]];
  end
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      act <= 1'b0;
      wr <= 1'b0;
      a <= 32'h0;
      m <= 32'h0;
      cnt <= 2'h0;
      hready <= 1'b1;
      hrdata <= 32'h0;
    end
    else
    begin
      if (wr_now)
        mem[a[5:2]] <= merged;
      if (hready)
      begin
        act <= htrans[1];
        a <= haddr;
        wr <= hwrite;
        m <= hsize == 3'h0 ? 32'hff << {haddr[1:0], 3'h0} :
          hsize == 3'h1 ? 32'hffff << {haddr[1], 4'h0} : 32'hffffffff;
        cnt <= waits;
        hready <= !htrans[1] || waits == 2'h0;
        // Stale data toggles so a late sample never matches by luck
        hrdata <= htrans[1] && waits == 2'h0 && !hwrite ? rd_word : ~hrdata;
      end
      else
      begin
        cnt <= cnt - 2'h1;
        hready <= cnt == 2'h1;
        hrdata <= cnt == 2'h1 && !wr ? mem[a[5:2]] : ~hrdata;
      end
    end
  end
endmodule // dsx_slave_model
`default_nettype wire

// ---- tb/tb_decorated_store_xor_bfi.sv ----
`default_nettype none
module tb_decorated_store_xor_bfi;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rstn = 0, up_hwrite = 0, up_hready, up_hresp, dn_hwrite;
  logic dn_hmastlock, dn_hready;
  logic [31:0] up_haddr = 0, up_hwdata = 0, up_hrdata, dn_haddr, dn_hwdata, dn_hrdata;
  logic [1:0] up_htrans = 0, dn_htrans, waits = 0;
  logic [2:0] up_hsize = 0, dn_hsize;
  logic [3:0] dn_hprot, up_hprot = 4'h0;
  int miscompares = 0, n_compared = 0;
  int mem [16];
  always #25 core_clk = ~core_clk;
  dsx_bit_manip_engine dut (.core_clk, .rstn, .up_haddr, .up_htrans, .up_hwrite,
    .up_hsize, .up_hprot, .up_hwdata, .up_hrdata, .up_hready, .up_hresp,
    .dn_haddr, .dn_htrans, .dn_hwrite, .dn_hsize, .dn_hprot, .dn_hmastlock,
    .dn_hwdata, .dn_hrdata, .dn_hready, .dn_hresp(1'b0));
  dsx_slave_model u_slave (.core_clk, .rstn, .haddr(dn_haddr), .htrans(dn_htrans),
    .hwrite(dn_hwrite), .hsize(dn_hsize), .hwdata(dn_hwdata), .waits,
    .hrdata(dn_hrdata), .hready(dn_hready));
  task automatic report_and_stop();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s,
    input logic [31:0] d, output logic [31:0] r);
    int k;
    up_haddr <= a;
    up_hwrite <= w;
    up_hsize <= s;
    up_hprot <= 4'($urandom);
    up_htrans <= 2'h2;
    k = 0;
    do @(posedge core_clk); while (!up_hready && ++k < 40);
    up_htrans <= 2'h0;
    up_hwdata <= d;
    do @(posedge core_clk); while (!up_hready && ++k < 40);
    r = up_hrdata;
    chk({31'h0, up_hresp}, 32'h0, "master error");
    if (k >= 40)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  initial
  begin
    logic [31:0] r, a, d, m, c, o, cm;
    int i, s, b, w, off, sh;
    r = $urandom(32'h9dce82dd);
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      mem[i] = $urandom;
      xfer(32'h40000000 + i * 4, 1'b1, 3'h2, mem[i], r);
    end
    $display("test init done");
    for (i = 0; i < 80; i++)
    begin
      if (i == 40)
      begin
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        $display("test mid-run reset done");
      end
      waits <= 2'($urandom % 3);
      s = $urandom % 3;
      cm = (64'h1 << (8 << s)) - 1;
      off = $urandom % 64 & ~((1 << s) - 1);
      sh = off % 4 * 8;
      b = $urandom % (8 << s);
      w = $urandom % (s == 0 ? 8 : 16);
      d = $urandom & cm;
      c = mem[off / 4] >> sh & cm;
      if ($urandom % 2)
      begin
        a = 32'h4c000000 | $urandom & 32'h03f00000 | off;
        o = c ^ d;
      end
      else
      begin
        a = 32'h50000000 | b << 23 | w << 19 | off;
        m = ((64'h1 << (w + 1)) - 1) << b & cm;
        o = c & ~m | d & m;
      end
      d = s == 0 ? {4{d[7:0]}} : s == 1 ? {2{d[15:0]}} : d;
      xfer(a, 1'b1, s[2:0], d, r);
      mem[off / 4] = mem[off / 4] & ~(cm << sh) | o << sh;
      xfer(32'h40000000 | off & ~3, 1'b0, 3'h2, 32'h0, r);
      chk(r, mem[off / 4], "read back word");
    end
    $display("test rmw done");
    report_and_stop();
  end
  initial
  begin
    #200us;
    miscompares++;
    report_and_stop();
  end
endmodule // tb_decorated_store_xor_bfi
`default_nettype wire
